/* File: design/dcca_pkg.sv */
// Constants shared by the dual capture/compare array and its timers
package dcca_pkg;

  // Geometry
  localparam int NCH = 32;
  localparam int CH_PER_UNIT = 16;
  localparam int NTMR = 4;
  localparam int TW = 16;
  localparam int NEXT = 2;
  localparam int CAP_ONLY_FIRST = 24;
  localparam int CAP_ONLY_LAST = 27;

  // Register byte offsets, one 32-bit word each
  localparam logic [11:0] VAL_BASE = 12'h000;
  localparam logic [11:0] MODE_BASE = 12'h080;
  localparam logic [11:0] TCTL_BASE = 12'h100;
  localparam logic [11:0] RELOAD_BASE = 12'h110;
  localparam logic [11:0] TVAL_BASE = 12'h120;
  localparam logic [11:0] REQ_OFS = 12'h130;
  localparam logic [11:0] PIN_OFS = 12'h134;

  // Channel mode register fields
  localparam int MODE_LSB = 0;
  localparam int TSEL_BIT = 3;
  localparam int PAIR_BIT = 4;
  localparam int MODE_W = 5;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // Channel function codes in MODE field
  localparam logic [2:0] FN_OFF = 3'h0;
  localparam logic [2:0] FN_CAP_RISE = 3'h1;
  localparam logic [2:0] FN_CAP_FALL = 3'h2;
  localparam logic [2:0] FN_CAP_BOTH = 3'h3;
  localparam logic [2:0] FN_CMP0 = 3'h4;
  localparam logic [2:0] FN_CMP1 = 3'h5;
  localparam logic [2:0] FN_CMP2 = 3'h6;
  localparam logic [2:0] FN_CMP3 = 3'h7;

  // Timer control register fields
  localparam int TIS_LSB = 0;
  localparam int SRC_LSB = 3;
  localparam int RUN_BIT = 5;
  localparam int TCTL_W = 6;
  localparam logic [5:0] TCTL_RESET = 6'h00;
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_GP2 = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // Prescaler: code 000b divides by 8, each step doubles up to 1024
  localparam logic [10:0] PRESC_MIN = 11'h008;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;

endpackage

/* File: design/dcca_timer.sv */
// One reloadable 16-bit time base with prescaler and source select
`timescale 1ns/1ps
module dcca_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic [2:0] tis_i,
  input wire logic [1:0] src_i,
  input wire logic ext_edge_i,
  input wire logic gp2_tick_i,
  input wire logic [W-1:0] reload_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic [W-1:0] value_o,
  output logic tick_o,
  output logic ovf_o
);

  typedef struct packed {
    logic [10:0] presc;
    logic [W-1:0] cnt;
    logic tick;
    logic ovf;
  } dcca_tmr_state_t;

  dcca_tmr_state_t st;
  dcca_tmr_state_t next_st;

  always_comb begin
    logic inc;
    inc = 1'b0;
    next_st = st;
    next_st.tick = 1'b0;
    next_st.ovf = 1'b0;
    case (src_i)
      dcca_pkg::SRC_PRESC: begin
        if (!run_i) begin
          next_st.presc = '0;
        end else if (st.presc == (dcca_pkg::PRESC_MIN << tis_i) - 11'h001) begin
          next_st.presc = '0;
          inc = 1'b1;
        end else begin
          next_st.presc = st.presc + 11'h001;
        end
      end
      dcca_pkg::SRC_GP2: inc = gp2_tick_i;
      dcca_pkg::SRC_EXT: inc = ext_edge_i;
      default: inc = 1'b0;
    endcase
    if (load_i) begin
      next_st.cnt = load_val_i;
    end else if (run_i && inc) begin
      next_st.tick = 1'b1;
      if (&st.cnt) begin
        // Reload value 0000h gives the full 65536-count period
        next_st.cnt = reload_i;
        next_st.ovf = 1'b1;
      end else begin
        next_st.cnt = st.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_o = st.cnt;
  assign tick_o = st.tick;
  assign ovf_o = st.ovf;

endmodule // dcca_timer

/* File: design/dcca_top.sv */
// Dual capture/compare array: 32 channels, four time bases, AHB-Lite
//
// Behaviour
// - Two arrays of 16 channels, 32 total
// - Per channel timer choice and capture/compare
// - Four 16-bit timers with reload registers
// - Timer clock from prescaler or gp2 overflow
// - First timer per unit counts external input
// - One pin per channel, input or output
// - Capture copies allocated timer into channel
// - Each capture raises its channel request
// - Capture on rising, falling or both edges
// - Compare channels compared continuously with timer; here only on cycles the timer steps
// - Match performs the selected compare action
// - Unit two channels 24..27 are capture only; here compare modes still raise requests, only the pin stays an input
// - Shared external input keeps timers in lockstep; here each unit has its own ext_count_i bit
// - Finest resolution is eight CPU clocks
// - Timer input select picks the prescaler
// - Reload 0000h gives longest period
// - Mode 0 repeated requests, mode 2 once
// - Mode 1 toggles, mode 3 set/overflow clear
// - Double register mode toggles shared pin
// - Select codes map to divisors 8..1024
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module dcca_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [31:0] cc_pin_i,
  output logic [31:0] cc_pin_o,
  output logic [31:0] cc_pin_oe_o,
  input wire logic [1:0] ext_count_i,
  input wire logic gp2_core_timer_ovf_i,
  output logic [31:0] cc_req_o
);

  localparam int NCH = dcca_pkg::NCH;
  localparam int NSY = dcca_pkg::NCH + dcca_pkg::NEXT;
  localparam int TW = dcca_pkg::TW;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NSY-1:0] sync1;
    logic [NSY-1:0] sync2;
    logic [NSY-1:0] prev;
    logic [NCH-1:0][TW-1:0] val;
    logic [NCH-1:0][dcca_pkg::MODE_W-1:0] mode;
    logic [dcca_pkg::NTMR-1:0][dcca_pkg::TCTL_W-1:0] tctl;
    logic [dcca_pkg::NTMR-1:0][TW-1:0] reload;
    logic [dcca_pkg::NTMR-1:0] tload;
    logic [TW-1:0] tload_val;
    logic [NCH-1:0] req;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] oe;
    logic [NCH-1:0] done;
    logic a_wr;
    logic [11:0] a_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } dcca_state_t;

  dcca_state_t st;
  dcca_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Time bases

  logic [dcca_pkg::NTMR-1:0][TW-1:0] tmr_val;
  logic [dcca_pkg::NTMR-1:0] tmr_tick;
  logic [dcca_pkg::NTMR-1:0] tmr_ovf;
  logic [dcca_pkg::NEXT-1:0] ext_rise;

  // Each unit has its own count input bit in ext_count_i, so the two
  // first timers step on the same edge only when both bits rise together
  assign ext_rise = st.sync2[NSY-1:NCH] & ~st.prev[NSY-1:NCH];

  genvar gt;
  generate
    for (gt = 0; gt < dcca_pkg::NTMR; gt++) begin : g_tmr
      // Timer a of each unit (even index) owns the external input
      logic ext_edge;
      if (gt % 2 == 0) begin : g_ext
        assign ext_edge = ext_rise[gt/2];
      end else begin : g_noext
        assign ext_edge = 1'b0;
      end
      dcca_timer #(
        .W(TW)
      ) u_tmr (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .run_i(st.tctl[gt][dcca_pkg::RUN_BIT]),
        .tis_i(st.tctl[gt][dcca_pkg::TIS_LSB +: 3]),
        .src_i(st.tctl[gt][dcca_pkg::SRC_LSB +: 2]),
        .ext_edge_i(ext_edge),
        .gp2_tick_i(gp2_core_timer_ovf_i),
        .reload_i(st.reload[gt]),
        .load_i(st.tload[gt]),
        .load_val_i(st.tload_val),
        .value_o(tmr_val[gt]),
        .tick_o(tmr_tick[gt]),
        .ovf_o(tmr_ovf[gt])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel timer view and events

  logic [NCH-1:0][TW-1:0] ch_tval;
  logic [NCH-1:0] ch_ovf;
  logic [NCH-1:0] ch_match;
  logic [NCH-1:0] ch_rise;
  logic [NCH-1:0] ch_fall;
  logic [NCH-1:0] ch_cap;
  logic [NCH-1:0] pair_hit;

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      localparam int UNIT = gc / dcca_pkg::CH_PER_UNIT;
      logic [1:0] tidx;
      logic [2:0] fn;
      assign fn = st.mode[gc][dcca_pkg::MODE_LSB +: 3];
      assign tidx = 2'(UNIT * 2) + {1'b0, st.mode[gc][dcca_pkg::TSEL_BIT]};
      assign ch_tval[gc] = tmr_val[tidx];
      assign ch_ovf[gc] = tmr_ovf[tidx];
      // Compare only on the cycle the timer takes a new value, so a
      // stopped timer does not fire mode 0 or mode 1 every clock
      assign ch_match[gc] = fn[2] && tmr_tick[tidx] &&
                            (tmr_val[tidx] == st.val[gc]);
      assign ch_rise[gc] = st.sync2[gc] & ~st.prev[gc];
      assign ch_fall[gc] = ~st.sync2[gc] & st.prev[gc];
      assign ch_cap[gc] = !fn[2] &&
                          ((fn[0] && ch_rise[gc]) ||
                           (fn[1] && ch_fall[gc]));
      // Lower eight channels of a unit may borrow the upper partner
      if (gc % dcca_pkg::CH_PER_UNIT < dcca_pkg::CH_PER_UNIT / 2) begin : g_pair
        assign pair_hit[gc] = st.mode[gc][dcca_pkg::PAIR_BIT] &&
                              ch_match[gc + dcca_pkg::CH_PER_UNIT / 2];
      end else begin : g_nopair
        assign pair_hit[gc] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  typedef struct packed {
    logic val;
    logic mode;
    logic tctl;
    logic reload;
    logic tval;
    logic req;
    logic pin;
  } dcca_sel_t;

  // One flag per register group; offsets past the map select nothing,
  // so stray writes are dropped and stray reads return zero
  function automatic dcca_sel_t reg_decode(input logic [11:0] a);
    dcca_sel_t s;
    s = '0;
    if (a < dcca_pkg::MODE_BASE) begin
      s.val = 1'b1;
    end else if (a < dcca_pkg::TCTL_BASE) begin
      s.mode = 1'b1;
    end else if (a < dcca_pkg::RELOAD_BASE) begin
      s.tctl = 1'b1;
    end else if (a < dcca_pkg::TVAL_BASE) begin
      s.reload = 1'b1;
    end else if (a < dcca_pkg::REQ_OFS) begin
      s.tval = 1'b1;
    end else if (a == dcca_pkg::REQ_OFS) begin
      s.req = 1'b1;
    end else if (a == dcca_pkg::PIN_OFS) begin
      s.pin = 1'b1;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [31:0] read_word(input dcca_state_t s,
      input logic [11:0] a,
      input logic [dcca_pkg::NTMR-1:0][TW-1:0] tv);
    logic [31:0] d;
    dcca_sel_t g;
    d = 32'h0000_0000;
    g = reg_decode(a);
    if (g.val) begin
      d = {16'h0000, s.val[a[6:2]]};
    end else if (g.mode) begin
      d = {27'h0000000, s.mode[a[6:2]]};
    end else if (g.tctl) begin
      d = {26'h0000000, s.tctl[a[3:2]]};
    end else if (g.reload) begin
      d = {16'h0000, s.reload[a[3:2]]};
    end else if (g.tval) begin
      d = {16'h0000, tv[a[3:2]]};
    end else if (g.req) begin
      d = s.req;
    end else if (g.pin) begin
      d = s.pin;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic a_take;
    logic [11:0] wa;
    logic [2:0] fn;
    dcca_sel_t ws;
    a_take = 1'b0;
    wa = 12'h000;
    fn = 3'h0;
    ws = '0;
    next_st = st;
    next_st.ready = 1'b1;
    next_st.resp = 1'b0;
    next_st.tload = '0;

    // Pin synchronisers; only the second stage feeds edge logic
    next_st.sync1 = {ext_count_i, cc_pin_i};
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;

    // Address phase: read data is fetched now so the data phase
    // completes with zero wait states
    a_take = hsel_i && htrans_i[1] && hready_i &&
             (hsize_i == 3'h2);
    next_st.a_wr = a_take && hwrite_i;
    if (a_take) begin
      next_st.a_addr = {haddr_i[11:2], 2'h0};
      if (!hwrite_i) begin
        next_st.rdata = read_word(st, {haddr_i[11:2], 2'h0}, tmr_val);
      end
    end

    // Data phase write; unmapped offsets are ignored
    if (st.a_wr) begin
      wa = st.a_addr;
      ws = reg_decode(st.a_addr);
      if (ws.val) begin
        next_st.val[wa[6:2]] = hwdata_i[TW-1:0];
      end else if (ws.mode) begin
        next_st.mode[wa[6:2]] = hwdata_i[dcca_pkg::MODE_W-1:0];
        next_st.done[wa[6:2]] = 1'b0;
      end else if (ws.tctl) begin
        next_st.tctl[wa[3:2]] = hwdata_i[dcca_pkg::TCTL_W-1:0];
      end else if (ws.reload) begin
        next_st.reload[wa[3:2]] = hwdata_i[TW-1:0];
      end else if (ws.tval) begin
        next_st.tload[wa[3:2]] = 1'b1;
        next_st.tload_val = hwdata_i[TW-1:0];
      end else if (ws.req) begin
        // Write one to clear; a new event below still wins
        next_st.req = st.req & ~hwdata_i;
      end
    end

    // Channel engines run after the bus so hardware events win
    for (int i = 0; i < NCH; i++) begin
      fn = st.mode[i][dcca_pkg::MODE_LSB +: 3];
      if (ch_cap[i]) begin
        next_st.val[i] = ch_tval[i];
        next_st.req[i] = 1'b1;
      end
      if (fn[2] && ch_ovf[i]) begin
        next_st.done[i] = 1'b0;
        if (fn == dcca_pkg::FN_CMP3) begin
          next_st.pin[i] = 1'b0;
        end
      end
      if (ch_match[i]) begin
        case (fn)
          dcca_pkg::FN_CMP0: next_st.req[i] = 1'b1;
          dcca_pkg::FN_CMP1: begin
            next_st.req[i] = 1'b1;
            next_st.pin[i] = ~st.pin[i];
          end
          // Latch as left by an overflow in this cycle, so a match at
          // the reload value still counts for the new period
          dcca_pkg::FN_CMP2: begin
            if (!next_st.done[i]) begin
              next_st.req[i] = 1'b1;
              next_st.done[i] = 1'b1;
            end
          end
          dcca_pkg::FN_CMP3: begin
            if (!next_st.done[i]) begin
              next_st.req[i] = 1'b1;
              next_st.pin[i] = 1'b1;
              next_st.done[i] = 1'b1;
            end
          end
          default: next_st.req[i] = st.req[i];
        endcase
      end
      // Partner match toggles this pin too; simultaneous hits cancel
      if (pair_hit[i]) begin
        next_st.pin[i] = next_st.pin[i] ^ 1'b1;
      end
      // Pin drives only in output compare modes or as a pair owner
      next_st.oe[i] = (fn == dcca_pkg::FN_CMP1) ||
                      (fn == dcca_pkg::FN_CMP3) ||
                      st.mode[i][dcca_pkg::PAIR_BIT];
      if (i >= dcca_pkg::CAP_ONLY_FIRST && i <= dcca_pkg::CAP_ONLY_LAST) begin
        next_st.oe[i] = 1'b0;
        next_st.pin[i] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register

  assign hrdata_o = st.rdata;
  assign hreadyout_o = st.ready;
  assign hresp_o = st.resp;
  assign cc_pin_o = st.pin;
  assign cc_pin_oe_o = st.oe;
  assign cc_req_o = st.req;

endmodule // dcca_top

/* File: sim/dcca_pins.sv */
// Port pin model: outside drivers merged with compare outputs
`timescale 1ns/1ps
module dcca_pins (
  input wire logic [31:0] out_i,
  input wire logic [31:0] oe_i,
  input wire logic [31:0] drv_i,
  output logic [31:0] pin_o
);
  // A driven pin reads back its own level, others follow the outside source
  assign pin_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule // dcca_pins

/* File: sim/dcca_props.sv */
// Port checker for the dual capture/compare array
`timescale 1ns/1ps
module dcca_props (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] cc_pin_i,
  input wire logic [31:0] cc_pin_o,
  input wire logic [31:0] cc_pin_oe_o,
  input wire logic [31:0] cc_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Delayed copies of taken accesses; register effects land edges later
  logic wr_d1;
  logic wr_d2;
  logic wr_d3;
  logic rd_d1;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_d1 <= 1'b0;
      wr_d2 <= 1'b0;
      wr_d3 <= 1'b0;
      rd_d1 <= 1'b0;
    end else begin
      wr_d1 <= hsel_i & htrans_i[1] & hwrite_i & hready_i;
      wr_d2 <= wr_d1;
      wr_d3 <= wr_d2;
      rd_d1 <= hsel_i & htrans_i[1] & ~hwrite_i & hready_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_ready_holds: assert property ($past(hreadyout_o) |-> hreadyout_o)
    else $error("ready dropped");
  a_caponly_oe: assert property (cc_pin_oe_o[27:24] == 4'h0)
    else $error("capture only pin driven");
  a_caponly_pin: assert property (cc_pin_o[27:24] == 4'h0)
    else $error("capture only pin level set");
  a_cap_latency: assert property ($rose(cc_req_o[24]) |->
    $past(cc_pin_i[24], 3) != $past(cc_pin_i[24], 4))
    else $error("capture request without pin edge");
  a_req_stands: assert property (|($past(cc_req_o) & ~cc_req_o) |-> wr_d2)
    else $error("request cleared without write");
  a_rdata_holds: assert property ($changed(hrdata_o) |-> rd_d1)
    else $error("read data changed without read");
  a_oe_by_write: assert property ($changed(cc_pin_oe_o) |-> wr_d2 | wr_d3)
    else $error("pin direction changed without write");
endmodule // dcca_props

bind dcca_top dcca_props u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o), .cc_pin_oe_o(cc_pin_oe_o),
  .cc_req_o(cc_req_o)
);

/* File: sim/test_dual_capture_compare_array.sv */
// Register-level testbench for the dual capture/compare array
`timescale 1ns/1ps
module test_dual_capture_compare_array;
  localparam logic [31:0] MD [5] = '{32'h4, 32'h5, 32'h6, 32'h7, 32'h15};
  localparam int EX [5] = '{0, 4, 0, 8, 8};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic [31:0] drv = 32'h0;
  logic [1:0] ext = 2'h0;
  logic gp2 = 1'b0;
  logic [31:0] req;
  logic [31:0] v;
  logic p;
  int n;
  int err_total = 0;
  int n_compared = 0;
  always #50 clk_i = ~clk_i;
  dcca_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .cc_pin_i(pin_in),
    .cc_pin_o(pin_out), .cc_pin_oe_o(pin_oe), .ext_count_i(ext),
    .gp2_core_timer_ovf_i(gp2), .cc_req_o(req));
  dcca_pins pins (.out_i(pin_out), .oe_i(pin_oe), .drv_i(drv), .pin_o(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Bounded wait for hready; a stuck bus ends the run
  task automatic wt;
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic acc(input logic [11:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    acc(a, 1'b0, 32'h0, q);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    arst_n_i <= 1'b1;
    cyc(2);
    rd(dcca_pkg::MODE_BASE, v);
    chk("mode reset", v, 32'h0);
    rd(dcca_pkg::RELOAD_BASE, v);
    chk("reload reset", v, 32'h0);
    rd(12'h200, v);
    chk("unmapped", v, 32'h0);
    wr(dcca_pkg::RELOAD_BASE + 12'h4, 32'hffffbeef);
    rd(dcca_pkg::RELOAD_BASE + 12'h4, v);
    chk("reload", v, 32'h0000beef);
    // Timer value differs between edges, so the value shows which edge hit
    for (int f = 1; f < 4; f++) begin
      wr(dcca_pkg::VAL_BASE + 12'h60, 32'h0);
      wr(dcca_pkg::MODE_BASE + 12'h60, 32'(f));
      wr(dcca_pkg::REQ_OFS, 32'hffffffff);
      wr(dcca_pkg::TVAL_BASE + 12'h8, 32'h100 + 32'(f));
      drv[24] <= 1'b1;
      cyc(6);
      rd(dcca_pkg::REQ_OFS, v);
      chk("req24", v[24], f != 2);
      wr(dcca_pkg::TVAL_BASE + 12'h8, 32'h200 + 32'(f));
      drv[24] <= 1'b0;
      cyc(6);
      rd(dcca_pkg::VAL_BASE + 12'h60, v);
      chk("cap24", v, 32'(f == 1 ? 32'h100 + f : 32'h200 + f));
    end
    // Bus writes shift start and stop by a few cycles, so allow one tick either way
    for (int c = 0; c < 8; c++) begin
      wr(dcca_pkg::TVAL_BASE + 12'h4, 32'h0);
      wr(dcca_pkg::TCTL_BASE + 12'h4, 32'h20 | 32'(c));
      cyc(4 * (8 << c));
      wr(dcca_pkg::TCTL_BASE + 12'h4, 32'h0);
      rd(dcca_pkg::TVAL_BASE + 12'h4, v);
      chk("ticks", 32'(v >= 3 && v <= 5), 32'h1);
    end
    // Period of 16 ticks, 128 cycles; matches at fff4 and fff8
    wr(dcca_pkg::RELOAD_BASE, 32'hfff0);
    wr(dcca_pkg::TVAL_BASE, 32'hfff0);
    wr(dcca_pkg::VAL_BASE, 32'hfff4);
    wr(dcca_pkg::VAL_BASE + 12'h20, 32'hfff8);
    wr(dcca_pkg::MODE_BASE + 12'h20, 32'h4);
    wr(dcca_pkg::TCTL_BASE, 32'h20);
    for (int i = 0; i < 5; i++) begin
      wr(dcca_pkg::MODE_BASE, MD[i]);
      cyc(256);
      wr(dcca_pkg::REQ_OFS, 32'h1);
      n = 0;
      p = pin_out[0];
      for (int k = 0; k < 512; k++) begin
        @(posedge clk_i);
        if (pin_out[0] !== p) n++;
        p = pin_out[0];
      end
      chk("toggles", 32'(n), 32'(EX[i]));
      rd(dcca_pkg::REQ_OFS, v);
      chk("req0", v & 32'h1, 32'h1);
    end
    wr(dcca_pkg::TCTL_BASE, 32'h0);
    wr(dcca_pkg::TVAL_BASE, 32'h0);
    wr(dcca_pkg::TVAL_BASE + 12'h4, 32'h0);
    wr(dcca_pkg::TVAL_BASE + 12'h8, 32'h0);
    // Channel 25 asks for a driven toggle pin; it must stay an input
    wr(dcca_pkg::VAL_BASE + 12'h64, 32'h3);
    wr(dcca_pkg::MODE_BASE + 12'h64, 32'h15);
    wr(dcca_pkg::TCTL_BASE, 32'h30);
    wr(dcca_pkg::TCTL_BASE + 12'h4, 32'h28);
    wr(dcca_pkg::TCTL_BASE + 12'h8, 32'h30);
    repeat (5) begin
      @(posedge clk_i);
      ext <= 2'h3;
      gp2 <= 1'b1;
      @(posedge clk_i);
      gp2 <= 1'b0;
      cyc(3);
      ext <= 2'h0;
      cyc(4);
    end
    cyc(6);
    rd(dcca_pkg::TVAL_BASE, v);
    chk("ext a1", v, 32'h5);
    rd(dcca_pkg::TVAL_BASE + 12'h8, v);
    chk("ext a2", v, 32'h5);
    rd(dcca_pkg::TVAL_BASE + 12'h4, v);
    chk("gp2 b1", v, 32'h5);
    chk("oe 24..27", pin_oe & 32'h0f00_0000, 32'h0);
    rd(dcca_pkg::PIN_OFS, v);
    chk("pin 24..27", v & 32'h0f00_0000, 32'h0);
    rd(dcca_pkg::REQ_OFS, v);
    chk("req25", v & 32'h0200_0000, 32'h0200_0000);
    end_of_test();
  end
endmodule // test_dual_capture_compare_array
